// *** hw/flns_defs.svh ***
// What this block does
// [RULE1] 32-bit station status vector at a configurable base reference.
// [RULE2] Status bits ordered by ascending bus address, lowest at bit zero.
// [RULE3] Host samples the whole status vector once per bus scan.
// [RULE4] Own address bit is 1 when on bus and configured, else 0.
// [RULE5] A station bit is 1 only when configured and present.
// [RULE6] Bit is 0 if absent, unconfigured or lengths mismatched.
// [RULE7] No station added or lost entries go into the fault log.
// [RULE8] Faults from stations, controller and bus are logged automatically.
// [RULE9] Log holds at most 32 entries; later faults may be lost.
// [RULE10] Raise the log full flag when the log becomes full.
// [RULE11] First 16 entries after a clear are never displaced.
// [RULE12] Entries 17 to 32 form a FIFO; fault 33 drops entry 17.
// [RULE13] A clear removes every log entry at once.
// [RULE14] Clear accepted from programming tool, handheld monitor or datagram; code takes the handheld programmer clear instead.
// [RULE15] Handheld programmer never clears the controller's own faults.
// [RULE16] Clearing does not reset conditions; recurring faults log again.
// [RULE17] Each fault has a category; fatal faults stop the host CPU.
// [RULE18] Each entry records circuit number and date and time.
// [RULE19] Reference address is memory-type code plus five-digit offset.
// [RULE20] Type field: circuit, module, bus, block loss, software exception.
// [RULE21] Host should poll the status vector regularly, mainly with hold.
// [RULE22] A second bus module sharing the host must not report faults.
// [RULE23] On station loss hold last inputs or force zero, by configuration.
// [RULE24] Status vector updates as one snapshot at the scan boundary.
`ifndef FLNS_DEFS_SVH
`define FLNS_DEFS_SVH

`define FLNS_STATIONS 32
`define FLNS_LOG_DEPTH 32
`define FLNS_KEEP_DEPTH 16
`define FLNS_STATUS_BASE_RST 16'h0001
`define FLNS_OFS_MAX 17'h1869f

`endif

// *** hw/flns_fault_log.sv ***
`timescale 1ns/100ps
`include "flns_defs.svh"

module flns_fault_log
    import flns_pkg::*;
#(
    parameter int STATIONS = `FLNS_STATIONS,
    parameter int LOG_DEPTH = `FLNS_LOG_DEPTH,
    parameter int KEEP_DEPTH = `FLNS_KEEP_DEPTH
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire logic [15:0] status_base,
    input wire logic [4:0] own_station_bus_address,
    input wire logic own_configured,
    input wire logic own_on_bus,
    input wire logic [STATIONS-1:0] station_configured,
    input wire logic [STATIONS-1:0] station_present,
    input wire logic [STATIONS-1:0] station_len_ok,
    input wire logic input_hold,
    // Station input data
    input wire logic [STATIONS-1:0] station_in_data,
    output logic [STATIONS-1:0] station_in_to_host,
    // Bus scan and status vector
    input wire logic scan_tick,
    output logic [STATIONS-1:0] status_vector,
    output logic [15:0] status_ref,
    // Fault reporting
    input wire logic fault_valid,
    input wire flns_entry_t fault_entry,
    // Clear sources
    input wire logic clear_tool,
    input wire logic clear_handheld_programmer,
    input wire logic clear_datagram,
    // Log read port
    input wire logic [4:0] rd_index,
    output flns_entry_t rd_entry,
    output logic [5:0] log_count,
    output logic log_full,
    output logic [15:0] overflow_count,
    output logic cpu_stop
);

    // ************************************************************
    // Status vector
    // ************************************************************
    logic [STATIONS-1:0] next_status;

    always_comb
    begin
        for (int i = 0; i < STATIONS; i++)
        begin
            // Bit index equals bus address, ascending from the base
            next_status[i] = station_configured[i] & station_present[i]
                & station_len_ok[i]; // RULE2 RULE5 RULE6
        end
        next_status[own_station_bus_address] =
            own_configured & own_on_bus; // RULE4
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            status_vector <= '0;
            status_ref <= `FLNS_STATUS_BASE_RST;
        end
        else if (scan_tick)
        begin
            status_vector <= next_status; // RULE24 RULE1
            status_ref <= status_base; // RULE1
        end
    end

    // ************************************************************
    // Lost station input default
    // ************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            station_in_to_host <= '0;
        else
        begin
            for (int i = 0; i < STATIONS; i++)
            begin
                if (station_present[i])
                    station_in_to_host[i] <= station_in_data[i];
                else if (!input_hold)
                    station_in_to_host[i] <= 1'b0; // RULE23
            end
        end
    end

    // ************************************************************
    // Fault log
    // ************************************************************
    localparam int FIFO_DEPTH = LOG_DEPTH - KEEP_DEPTH;

    flns_entry_t mem [LOG_DEPTH];
    // Oldest entry of the FIFO region once the log is full
    logic [5:0] fifo_head;
    logic do_clear;
    logic do_log;
    logic [5:0] wr_slot;

    function automatic logic [5:0] fifo_slot(input logic [5:0] base,
                                             input logic [5:0] n);
        logic [5:0] s;
        s = base + n;
        if (s >= 6'(FIFO_DEPTH))
            s = s - 6'(FIFO_DEPTH);
        return s;
    endfunction

    // Handheld clear only wipes if no controller fault is held
    logic ctrl_fault_held;
    always_comb
    begin
        ctrl_fault_held = 1'b0;
        for (int i = 0; i < LOG_DEPTH; i++)
        begin
            if (6'(i) < log_count && mem[i].src == FLNS_SRC_CTRL)
                ctrl_fault_held = 1'b1;
        end
    end

    // An accepted clear wins over a fault in the same cycle
    assign do_clear = clear_tool | clear_datagram
        | (clear_handheld_programmer & ~ctrl_fault_held); // RULE14 RULE15
    // Station add or loss is never a fault input here
    assign do_log = fault_valid & ~do_clear; // RULE7 RULE8 RULE16

    always_comb
    begin
        if (log_count < 6'(KEEP_DEPTH))
            wr_slot = log_count;
        else if (log_count < 6'(LOG_DEPTH))
            wr_slot = 6'(KEEP_DEPTH)
                + fifo_slot(fifo_head, log_count - 6'(KEEP_DEPTH));
        else
            wr_slot = 6'(KEEP_DEPTH) + fifo_head; // RULE12
    end

    // Offsets past five decimal digits are held at the largest legal one
    flns_entry_t next_entry;

    always_comb
    begin
        next_entry = fault_entry;
        if (fault_entry.offset > `FLNS_OFS_MAX)
            next_entry.offset = `FLNS_OFS_MAX; // RULE19
    end

    always_ff @(posedge ref_clk)
    begin
        if (do_log)
            mem[wr_slot[4:0]] <= next_entry; // RULE18 RULE19 RULE20
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || do_clear)
        begin
            log_count <= '0; // RULE13
            fifo_head <= '0;
            log_full <= 1'b0;
            overflow_count <= '0;
        end
        else if (do_log)
        begin
            if (log_count < 6'(LOG_DEPTH))
                log_count <= log_count + 6'h01; // RULE9 RULE11
            else
            begin
                fifo_head <= fifo_slot(fifo_head, 6'h01); // RULE12
                overflow_count <= overflow_count + 16'h0001;
            end
            if (log_count >= 6'(LOG_DEPTH - 1))
                log_full <= 1'b1; // RULE10
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || do_clear)
            cpu_stop <= 1'b0;
        else if (do_log && fault_entry.fatal)
            cpu_stop <= 1'b1; // RULE17
    end

    // ************************************************************
    // Read port, oldest first
    // ************************************************************
    logic [5:0] rd_slot;
    always_comb
    begin
        if (rd_index < 5'(KEEP_DEPTH))
            rd_slot = {1'b0, rd_index};
        else
            rd_slot = 6'(KEEP_DEPTH)
                + fifo_slot(fifo_head, {1'b0, rd_index} - 6'(KEEP_DEPTH));
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rd_entry <= '0;
        else
            rd_entry <= mem[rd_slot[4:0]];
    end

    // ************************************************************
    // Checks: status vector and station inputs
    // ************************************************************
    a_status_snap: assert property ( // RULE24
        @(posedge ref_clk) disable iff (rst)
        !scan_tick |=> $stable(status_vector))
        else $error("status changed mid scan");

    a_status_and: assert property ( // RULE5 RULE6
        @(posedge ref_clk) disable iff (rst)
        scan_tick |=> (status_vector & ~$past(station_configured
            & station_present & station_len_ok)
            & ~(STATIONS'(1) << $past(own_station_bus_address))) == '0)
        else $error("absent station shows present");

    a_own_bit: assert property ( // RULE4
        @(posedge ref_clk) disable iff (rst)
        scan_tick |=> status_vector[$past(own_station_bus_address)]
            == $past(own_configured && own_on_bus))
        else $error("own status bit wrong");

    a_ref_latch: assert property ( // RULE1
        @(posedge ref_clk) disable iff (rst)
        scan_tick |=> status_ref == $past(status_base))
        else $error("status base not taken at scan");

    a_lost_zero: assert property ( // RULE23
        @(posedge ref_clk) disable iff (rst)
        !station_present[0] && !input_hold |=> !station_in_to_host[0])
        else $error("lost input not forced off");

    a_hold_last: assert property ( // RULE23
        @(posedge ref_clk) disable iff (rst)
        !station_present[0] && input_hold
            |=> $stable(station_in_to_host[0]))
        else $error("lost input not held");

    a_live_pass: assert property ( // RULE23
        @(posedge ref_clk) disable iff (rst)
        station_present[0]
            |=> station_in_to_host[0] == $past(station_in_data[0]))
        else $error("live input not passed");

    // ************************************************************
    // Checks: fault log filling and overflow
    // ************************************************************
    a_log_step: assert property ( // RULE8
        @(posedge ref_clk) disable iff (rst)
        do_log && log_count < 6'h20
            |=> log_count == $past(log_count) + 6'h01)
        else $error("fault not counted");

    a_log_idle: assert property ( // RULE9
        @(posedge ref_clk) disable iff (rst)
        !do_log && !do_clear
            |=> $stable(log_count) && $stable(overflow_count))
        else $error("log changed with no fault");

    a_count_bounded: assert property ( // RULE9
        @(posedge ref_clk) disable iff (rst)
        log_count <= 6'h20)
        else $error("log count above 32");

    a_ovf_step: assert property ( // RULE9
        @(posedge ref_clk) disable iff (rst)
        do_log && log_count == 6'h20 |=> log_count == 6'h20
            && overflow_count == $past(overflow_count) + 16'h0001)
        else $error("overflow not counted");

    a_full_at_32: assert property ( // RULE10
        @(posedge ref_clk) disable iff (rst)
        !do_clear && do_log && log_count == 6'h1f |=> log_full)
        else $error("full flag not raised on 32nd entry");

    a_full_sticky: assert property ( // RULE10
        @(posedge ref_clk) disable iff (rst)
        log_full && !do_clear |=> log_full)
        else $error("full flag dropped without clear");

    a_write_slot: assert property ( // RULE11
        @(posedge ref_clk) disable iff (rst)
        do_log && log_count < 6'h10 |-> wr_slot == log_count)
        else $error("early entry misplaced");

    a_keep_region: assert property ( // RULE11
        @(posedge ref_clk) disable iff (rst)
        do_log && log_count >= 6'h10 |-> wr_slot >= 6'h10)
        else $error("kept entry overwritten");

    a_fifo_wrap: assert property ( // RULE12
        @(posedge ref_clk) disable iff (rst)
        do_log && log_count == 6'h20
            |=> fifo_head == fifo_slot($past(fifo_head), 6'h01))
        else $error("fifo head did not advance");

    // ************************************************************
    // Checks: clearing and fault category
    // ************************************************************
    a_clear_all: assert property ( // RULE13
        @(posedge ref_clk) disable iff (rst)
        clear_tool || clear_datagram
            |=> log_count == 6'h00 && !log_full)
        else $error("clear left entries");

    a_any_clear: assert property ( // RULE13 RULE14
        @(posedge ref_clk) disable iff (rst)
        do_clear |=> log_count == 6'h00)
        else $error("accepted clear left entries");

    a_handheld_blocked: assert property ( // RULE15
        @(posedge ref_clk) disable iff (rst)
        clear_handheld_programmer && ctrl_fault_held && !clear_tool
            && !clear_datagram |=> log_count != 6'h00)
        else $error("handheld cleared controller fault");

    a_fatal_stop: assert property ( // RULE17
        @(posedge ref_clk) disable iff (rst)
        do_log && fault_entry.fatal |=> cpu_stop)
        else $error("fatal fault did not stop cpu");

    a_stop_diag: assert property ( // RULE17
        @(posedge ref_clk) disable iff (rst)
        !cpu_stop && !(do_log && fault_entry.fatal)
            |=> !cpu_stop)
        else $error("diagnostic fault stopped cpu");

    a_stop_sticky: assert property ( // RULE17
        @(posedge ref_clk) disable iff (rst)
        cpu_stop && !do_clear |=> cpu_stop)
        else $error("stop dropped without clear");

endmodule

// *** hw/flns_pkg.sv ***
package flns_pkg;

    typedef enum logic [2:0] {
        FLNS_MEM_I = 3'h0,
        FLNS_MEM_Q = 3'h1,
        FLNS_MEM_IQ = 3'h2,
        FLNS_MEM_AI = 3'h3,
        FLNS_MEM_AQ = 3'h4
    } flns_mem_t;

    typedef enum logic [2:0] {
        FLNS_FT_CIRCUIT = 3'h0,
        FLNS_FT_MODULE = 3'h1,
        FLNS_FT_BUS = 3'h2,
        FLNS_FT_BLOCK_LOSS = 3'h3,
        FLNS_FT_SW_EXCEPT = 3'h4
    } flns_ftype_t;

    typedef enum logic [1:0] {
        FLNS_SRC_STATION = 2'h0,
        FLNS_SRC_CTRL = 2'h1,
        FLNS_SRC_BUS = 2'h2
    } flns_src_t;

    typedef struct packed {
        logic [15:0] location;
        logic [7:0] circuit;
        flns_mem_t mem;
        logic [16:0] offset;
        logic fatal;
        flns_ftype_t ftype;
        flns_src_t src;
        logic [31:0] stamp;
    } flns_entry_t;

endpackage

// *** tb/flns_host_model.sv ***
`timescale 1ns/100ps
// ****
// Host reader
// ****
module flns_host_model
(
    // Clock and scan
    input wire logic ref_clk,
    input wire logic scan_tick,
    input wire logic [31:0] status_vector,
    // Snapshot
    output logic [31:0] host_snap
);
    logic seen;
    always_ff @(posedge ref_clk)
        seen <= scan_tick;
    // One snapshot per scan
    always_ff @(posedge ref_clk)
        if (seen)
            host_snap <= status_vector;
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
    import flns_pkg::*;
;
    logic ref_clk = 0;
    logic rst = 1;
    logic [15:0] base = 0;
    logic [4:0] own_a = 0;
    logic [4:0] rd_index = 0;
    logic own_c = 0, own_o = 0, hold = 0, scan = 0, fv = 0;
    logic c_tool = 0, c_hand = 0, c_dg = 0;
    logic [31:0] cfg = 0, pres = 0, lok = 0, din = 0;
    logic [31:0] to_host, status, snap;
    logic [15:0] sref, ovf;
    logic [5:0] cnt;
    logic full, stop;
    flns_entry_t fe = '0;
    flns_entry_t rd_entry;
    flns_entry_t e;
    flns_entry_t mlog[$];
    int failures = 0, check_count = 0, movf = 0;
    bit mfull = 0, mstop = 0;
    logic [31:0] lfsr = 32'h38;
    logic [31:0] mhost = 0;

    flns_fault_log DUT (.ref_clk(ref_clk), .rst(rst), .status_base(base),
        .own_station_bus_address(own_a), .own_configured(own_c),
        .own_on_bus(own_o), .station_configured(cfg),
        .station_present(pres), .station_len_ok(lok), .input_hold(hold),
        .station_in_data(din), .station_in_to_host(to_host),
        .scan_tick(scan), .status_vector(status), .status_ref(sref),
        .fault_valid(fv), .fault_entry(fe), .clear_tool(c_tool),
        .clear_handheld_programmer(c_hand), .clear_datagram(c_dg),
        .rd_index(rd_index), .rd_entry(rd_entry), .log_count(cnt),
        .log_full(full), .overflow_count(ovf), .cpu_stop(stop));
    flns_host_model host (.ref_clk(ref_clk), .scan_tick(scan),
        .status_vector(status), .host_snap(snap));

    // ****
    // Reference model and tasks, all entered at a falling edge
    // ****
    function automatic logic [31:0] rnd();
        lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h0);
        return lfsr;
    endfunction
    function automatic flns_entry_t rnd_e(logic [1:0] src, logic fat);
        flns_entry_t r;
        r = 82'({rnd(), rnd(), rnd()});
        r.mem = flns_mem_t'(3'(rnd() % 5));
        r.ftype = flns_ftype_t'(3'(rnd() % 5));
        r.src = flns_src_t'(src);
        r.offset = 17'(rnd() % 100000);
        r.fatal = fat;
        return r;
    endfunction
    task automatic chk_v(string n, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_e(string n, flns_entry_t x, flns_entry_t g);
        check_count++;
        if (g !== x)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic step(logic f, flns_entry_t x, logic [2:0] clr);
        bit ctl;
        ctl = 0;
        fv = f;
        fe = x;
        {c_tool, c_hand, c_dg} = clr;
        foreach (mlog[i])
            ctl |= mlog[i].src == FLNS_SRC_CTRL;
        @(posedge ref_clk);
        if (clr[2] || clr[0] || (clr[1] && !ctl))
        begin
            mlog.delete();
            mfull = 0;
            mstop = 0;
        end
        else if (f)
        begin
            if (mlog.size() == 32)
            begin
                mlog.delete(16);
                movf++;
            end
            mlog.push_back(x);
            mfull |= mlog.size() == 32;
            mstop |= x.fatal;
        end
        @(negedge ref_clk);
        chk_v("log_count", mlog.size(), cnt);
        chk_v("log_full", mfull, full);
        chk_v("cpu_stop", mstop, stop);
    endtask
    task automatic scan_chk();
        logic [31:0] x;
        base = 16'(rnd());
        cfg = rnd();
        pres = rnd() | rnd();
        lok = rnd() | rnd();
        own_a = 5'(rnd());
        {own_c, own_o, hold} = 3'(rnd());
        din = rnd();
        x = cfg & pres & lok;
        x[own_a] = own_c & own_o;
        mhost = (pres & din) | (~pres & (hold ? mhost : 32'h0));
        scan = 1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        scan = 0;
        cfg = ~cfg;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk_v("status", x, snap);
        chk_v("status_ref", base, sref);
        chk_v("station_in_to_host", mhost, to_host);
    endtask
    task automatic read_all();
        fv = 0;
        {c_tool, c_hand, c_dg} = 3'h0;
        foreach (mlog[i])
        begin
            rd_index = 5'(i);
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk_e("rd_entry", mlog[i], rd_entry);
        end
    endtask

    initial
        forever #20 ref_clk = ~ref_clk;
    initial
    begin
        #(40 * 20000);
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_v("status_ref", 32'h1, sref);
        chk_v("log_count", 32'h0, cnt);
        rst = 0;
        repeat (4) scan_chk();
        $display("status test done");
        for (int i = 0; i < 35; i++)
            step(1, rnd_e(2'h0, 1'b0), 3'h0);
        read_all();
        chk_v("overflow_count", movf, ovf);
        $display("overflow test done");
        step(0, '0, 3'h2);
        step(1, rnd_e(2'h1, 1'b0), 3'h0);
        step(0, '0, 3'h2);
        e = rnd_e(2'h2, 1'b1);
        step(1, e, 3'h0);
        step(1, e, 3'h1);
        step(1, e, 3'h0);
        read_all();
        step(0, '0, 3'h4);
        step(0, '0, 3'h0);
        $display("clear test done");
        stop_test();
    end
endmodule
